// ### verilog/dwecc_regs.svh
// constants for the doubleword check logic: logout offsets, code fields
// assumes inclusion by bare name from verilog/ files
`ifndef DWECC_REGS_SVH
`define DWECC_REGS_SVH
`define DWECC_CODE_ADDR    12'h0E8
`define DWECC_CODE_LAST    12'h0EF
`define DWECC_FAIL_ADDR    12'h0F8
`define DWECC_FAIL_LAST    12'h0F9
`define DWECC_MC_PD_BIT    6'h01
`define DWECC_MC_SE_BIT    6'h10
`define DWECC_MC_FSA_BIT   6'h18
`define DWECC_RETRY_MAX    1'h1
`define DWECC_FSA_W        16
`endif

// ### verilog/dwecc_pkg.sv
// types for the doubleword check logic
// assumes nothing beyond a SystemVerilog compiler
package dwecc_pkg;
  typedef enum logic [3:0] {
    DWECC_IDLE  = 4'b0001,
    DWECC_RETRY = 4'b0010,
    DWECC_MCHK  = 4'b0100,
    DWECC_IOREP = 4'b1000
  } dwecc_state_t;
endpackage

// ### verilog/dwecc_code.sv
// combinational hamming secded generator and syndrome decoder, 64+8 bits
// assumes the caller registers the results
`timescale 1ns/10ps
`default_nettype none
module dwecc_code (
  input  wire logic [63:0] data,
  input  wire logic [7:0]  chk_in,
  output logic      [7:0]  chk_gen,
  output logic      [63:0] data_fix,
  output logic             err_single,
  output logic             err_multi
);
  // each data bit sits at a non-power-of-two hamming position
  function automatic logic [6:0] dwecc_pos(input int idx);
    int p;
    int n;
    p = 0;
    n = -1;
    for (int k = 1; k < 128; k++) begin
      if ((k & (k - 1)) != 0 && n < idx) begin
        n = n + 1;
        p = k;
      end
    end
    return p[6:0];
  endfunction

  logic [6:0] syn;
  logic       ovr;
  logic [6:0] hgen;
  always_comb begin
    hgen = 7'h00;
    for (int i = 0; i < 64; i++) begin
      if (data[i]) begin
        hgen = hgen ^ dwecc_pos(i);
      end
    end
    // bit 7 is overall parity across data and hamming bits
    chk_gen = {^data ^ ^hgen, hgen};
    syn = hgen ^ chk_in[6:0];
    ovr = ^data ^ ^chk_in;
    err_single = ovr;
    err_multi = !ovr && (syn != 7'h00);
    data_fix = data;
    for (int i = 0; i < 64; i++) begin
      if (ovr && syn == dwecc_pos(i)) begin
        data_fix[i] = ~data[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/dwecc_top.sv
// doubleword storage check: store encode, fetch check/correct, error report
// assumes storage returns fetch data one cycle after a fetch strobe
//
// Summary of operation
// R01: one eight-bit code per doubleword
// R02: 72-bit stored word, checked every fetch
// R03: regenerate byte parity on fetched data
// R04: single-bit error inverted silently
// R05: double and multiple errors flagged uncorrectable
// R06: store drops parity, writes code
// R07: retry retryable instruction exactly once
// R08: single-bit on retry continues normally
// R09: machine check only while enabled
// R10: corrected single bit raises nothing
// R11: failing address logged on machine check
// R12: i/o fetch errors reported with i/o interruption
// R13: outside data keeps byte parity
// R14: eight-byte code at 232-239
// R15: address at 248-249, bit 24 valid
// R16: hamming secded code, syndrome selects bit
// R17: odd parity, flag with data
`timescale 1ns/10ps
`default_nettype none
`include "dwecc_regs.svh"
module dwecc_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        st_valid,
  input  wire logic [63:0] st_data,
  input  wire logic [7:0]  st_par,
  input  wire logic [15:0] acc_addr,
  input  wire logic        fe_req,
  input  wire logic        fe_io,
  input  wire logic        fe_retryable,
  input  wire logic [71:0] mem_rdata,
  input  wire logic        mc_enable,
  output logic             mem_we,
  output logic [71:0]      mem_wdata,
  output logic             fe_valid,
  output logic [63:0]      fe_data,
  output logic [7:0]       fe_par,
  output logic             fe_uncorr,
  output logic             retry_req,
  output logic             mc_int,
  output logic             io_err_rep,
  output logic             log_we,
  output logic [11:0]      log_addr,
  output logic [63:0]      log_data
);
  logic [7:0]  st_chk;
  logic [63:0] fix;
  logic        e1;
  logic        em;
  logic        pend_q;
  logic        pio_q;
  logic        pret_q;
  logic [15:0] paddr_q;
  logic        retried_q;
  logic [15:0] fail_q;
  logic [1:0]  lstep_q;
  dwecc_pkg::dwecc_state_t st_q;

  // R16 secded encode
  dwecc_code u_enc (
    .data       (st_data),
    .chk_in     (8'h00),
    .chk_gen    (st_chk),
    .data_fix   (),
    .err_single (),
    .err_multi  ()
  );
  // R02 check on fetch
  dwecc_code u_dec (
    .data       (mem_rdata[63:0]),
    .chk_in     (mem_rdata[71:64]),
    .chk_gen    (),
    .data_fix   (fix),
    .err_single (e1),
    .err_multi  (em)
  );

  // R06 store path; parity in is dropped on purpose
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we    <= 1'b0;
      mem_wdata <= 72'h00_0000_0000_0000_0000;
    end else begin
      mem_we    <= st_valid;
      // R01 one code per doubleword
      if (st_valid) begin
        mem_wdata <= {st_chk, st_data};
      end
    end
  end

  // fetch context, data arrives the next cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q  <= 1'b0;
      pio_q   <= 1'b0;
      pret_q  <= 1'b0;
      paddr_q <= 16'h0000;
    end else begin
      pend_q <= fe_req;
      if (fe_req) begin
        pio_q   <= fe_io;
        pret_q  <= fe_retryable;
        paddr_q <= acc_addr;
      end
    end
  end

  // R04 corrected data out; R17 flag same cycle as data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_valid  <= 1'b0;
      fe_data   <= 64'h0000_0000_0000_0000;
      fe_par    <= 8'h00;
      fe_uncorr <= 1'b0;
    end else begin
      fe_valid  <= pend_q;
      fe_uncorr <= pend_q && em;
      if (pend_q) begin
        fe_data <= fix;
        // R03 R13 R17 odd parity per byte
        for (int b = 0; b < 8; b++) begin
          fe_par[b] <= ~^fix[b*8 +: 8];
        end
      end
    end
  end

  // error reaction; R10 single-bit never leaves idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= dwecc_pkg::DWECC_IDLE;
      retried_q  <= 1'b0;
      retry_req  <= 1'b0;
      mc_int     <= 1'b0;
      io_err_rep <= 1'b0;
      fail_q     <= 16'h0000;
    end else begin
      retry_req  <= 1'b0;
      mc_int     <= 1'b0;
      io_err_rep <= 1'b0;
      case (st_q)
        dwecc_pkg::DWECC_IDLE, dwecc_pkg::DWECC_RETRY: begin
          if (pend_q && em) begin
            fail_q <= paddr_q;
            if (pio_q) begin
              // R12 i/o errors go to i/o interruption
              st_q <= dwecc_pkg::DWECC_IOREP;
            end else if (pret_q && !retried_q) begin
              // R07 one retry only
              retried_q <= `DWECC_RETRY_MAX;
              retry_req <= 1'b1;
              st_q      <= dwecc_pkg::DWECC_RETRY;
            end else begin
              st_q <= dwecc_pkg::DWECC_MCHK;
            end
          end else if (pend_q && st_q == dwecc_pkg::DWECC_RETRY) begin
            // R08 retry clean or corrected, carry on
            retried_q <= 1'b0;
            st_q      <= dwecc_pkg::DWECC_IDLE;
          end
        end
        dwecc_pkg::DWECC_MCHK: begin
          retried_q <= 1'b0;
          // R09 held pending until enabled
          if (mc_enable && lstep_q == 2'd0) begin
            mc_int <= 1'b1;
            st_q   <= dwecc_pkg::DWECC_IDLE;
          end
        end
        dwecc_pkg::DWECC_IOREP: begin
          // an i/o error seen during a retry ends that retry too
          retried_q  <= 1'b0;
          io_err_rep <= 1'b1;
          st_q       <= dwecc_pkg::DWECC_IDLE;
        end
        default: st_q <= dwecc_pkg::DWECC_IDLE;
      endcase
    end
  end

  // logout writes, launched as the interruption is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lstep_q  <= 2'd0;
      log_we   <= 1'b0;
      log_addr <= 12'h000;
      log_data <= 64'h0000_0000_0000_0000;
    end else begin
      log_we <= 1'b0;
      if (st_q == dwecc_pkg::DWECC_MCHK && mc_enable && lstep_q == 2'd0)
      begin
        lstep_q <= 2'd1;
      end else if (lstep_q == 2'd1) begin
        // R14 code at 232-239: damage, storage error, addr valid
        log_we   <= 1'b1;
        log_addr <= `DWECC_CODE_ADDR;
        log_data <= (64'h8000_0000_0000_0000 >> `DWECC_MC_PD_BIT)
                  | (64'h8000_0000_0000_0000 >> `DWECC_MC_SE_BIT)
                  | (64'h8000_0000_0000_0000 >> `DWECC_MC_FSA_BIT);
        lstep_q  <= 2'd2;
      end else if (lstep_q == 2'd2) begin
        // R11 R15 failing address at 248-249
        log_we   <= 1'b1;
        log_addr <= `DWECC_FAIL_ADDR;
        log_data <= {fail_q, 48'h0000_0000_0000};
        lstep_q  <= 2'd0;
      end
    end
  end

  sequence ue_seen_s;
    pend_q && em && !pio_q && !(pret_q && !retried_q)
    && (st_q == dwecc_pkg::DWECC_IDLE || st_q == dwecc_pkg::DWECC_RETRY);
  endsequence

  property mc_gate_p;
    @(posedge core_clk) disable iff (!rst_n) mc_int |-> $past(mc_enable);
  endproperty
  mc_gated_a: assert property (mc_gate_p) // R09
    else $error("machine check while disabled");
  single_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q && e1 && st_q == dwecc_pkg::DWECC_IDLE |=> !fe_uncorr
    ##1 !mc_int) // R10
    else $error("single-bit raised an error");
  uncorr_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q && em |=> fe_uncorr && fe_valid) // R05
    else $error("multi-bit not flagged");
  store_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_valid |=> mem_we && mem_wdata == {$past(st_chk), $past(st_data)})
    // R06
    else $error("store word wrong");
  parity_odd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fe_valid |-> ^{fe_par[0], fe_data[7:0]}) // R17
    else $error("byte parity not odd");
  retry_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    retry_req |-> !$past(retried_q)) // R07
    else $error("second retry");
  io_report_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q && em && pio_q && st_q == dwecc_pkg::DWECC_IDLE
    |=> ##1 io_err_rep && !mc_int) // R12
    else $error("i/o error not reported");
  logout_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mc_int |=> log_we && log_addr == `DWECC_CODE_ADDR && log_data[39]
    ##1 log_we && log_addr == `DWECC_FAIL_ADDR) // R14
    else $error("logout order wrong");
  addr_log_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ue_seen_s |=> fail_q == $past(paddr_q)) // R11
    else $error("failing address not kept");
  correct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q |=> fe_data == $past(fix)) // R04
    else $error("corrected data not delivered");
endmodule
`default_nettype wire

// ### verification/dwecc_mem_model.sv
// storage array model facing the check logic
// assumes the bench drives acc_addr with st_valid and fe_req
`timescale 1ns/10ps
`default_nettype none
module dwecc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        st_valid,
  input  wire logic [15:0] acc_addr,
  input  wire logic        fe_req,
  input  wire logic [71:0] flip,
  input  wire logic        mem_we,
  input  wire logic [71:0] mem_wdata,
  output logic      [71:0] mem_rdata
);
  logic [71:0] word_q [16];
  logic [3:0]  wa_q;
  initial mem_rdata = 72'h0;
  always @(posedge core_clk) begin
    if (st_valid)
      wa_q <= acc_addr[3:0];
    if (mem_we)
      word_q[wa_q] <= mem_wdata;
  end
  // answer next cycle; flip injects faults, idle bus toggles
  always @(posedge core_clk) begin
    if (fe_req)
      mem_rdata <= word_q[acc_addr[3:0]] ^ flip;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

// ### verification/test_dwecc_top.sv
// bench for the doubleword check logic
// assumes storage model answers a fetch on the next cycle
`timescale 1ns/10ps
`default_nettype none
`include "dwecc_regs.svh"
module test_dwecc_top;
  logic core_clk = 0, rst_n = 0, st_valid = 0, fe_req = 0, fe_io = 0;
  logic fe_retryable = 0, mc_enable = 1, mem_we, fe_valid, fe_uncorr;
  logic retry_req, mc_int, io_err_rep, log_we;
  logic [63:0] st_data = 64'h0, fe_data, log_data;
  logic [7:0]  st_par = 8'h00, fe_par;
  logic [15:0] acc_addr = 16'h0000;
  logic [71:0] mem_rdata, mem_wdata, flip = 72'h0;
  logic [11:0] log_addr;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  logic [63:0] dv [5] = '{64'h0123_4567_89AB_CDEF, 64'hFFFF_FFFF_FFFF_FFFF,
    64'h0, 64'h8000_0000_0000_0001, 64'hA5A5_5A5A_0F0F_F0F0};
  logic [71:0] fv [5] = '{72'h0, 72'h1, 72'h8000_0000_0000_0000,
    72'h1_0000_0000_0000_0000, 72'h80_0000_0000_0000_0000};
  always #12.5 core_clk = ~core_clk;
  dwecc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .st_valid(st_valid),
    .st_data(st_data), .st_par(st_par), .acc_addr(acc_addr),
    .fe_req(fe_req), .fe_io(fe_io), .fe_retryable(fe_retryable),
    .mem_rdata(mem_rdata), .mc_enable(mc_enable), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .fe_valid(fe_valid), .fe_data(fe_data),
    .fe_par(fe_par), .fe_uncorr(fe_uncorr), .retry_req(retry_req),
    .mc_int(mc_int), .io_err_rep(io_err_rep), .log_we(log_we),
    .log_addr(log_addr), .log_data(log_data));
  dwecc_mem_model mem (.core_clk(core_clk), .st_valid(st_valid),
    .acc_addr(acc_addr), .fe_req(fe_req), .flip(flip), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  function automatic logic [7:0] opar(input logic [63:0] d);
    for (int b = 0; b < 8; b++)
      opar[b] = ~^d[8*b +: 8];
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic st(input logic [15:0] a, input logic [63:0] d);
    @(negedge core_clk);
    acc_addr = a;
    st_data = d;
    st_par = ~opar(d);
    st_valid = 1;
    @(negedge core_clk);
    st_valid = 0;
    chk("mem_we", mem_we, 1);
    chk("mem_wdata", mem_wdata[63:0], d);
  endtask
  task automatic logchk(input logic [15:0] a);
    @(negedge core_clk);
    chk("log_we", log_we, 1);
    chk("log_addr", log_addr, `DWECC_CODE_ADDR);
    chk("log_code", log_data, 64'h4000_8080_0000_0000);
    @(negedge core_clk);
    chk("log_addr2", log_addr, `DWECC_FAIL_ADDR);
    chk("log_fsa", log_data[63:48], a);
  endtask
  task automatic fe(input logic [15:0] a, input logic [63:0] d,
      input logic [71:0] f, input logic io, rt, u, rq, mc);
    @(negedge core_clk);
    acc_addr = a;
    flip = f;
    fe_io = io;
    fe_retryable = rt;
    fe_req = 1;
    @(negedge core_clk);
    fe_req = 0;
    @(negedge core_clk);
    chk("fe_valid", fe_valid, 1);
    chk("fe_data", fe_data, u ? d ^ f[63:0] : d);
    chk("fe_par", fe_par, opar(u ? d ^ f[63:0] : d));
    chk("fe_uncorr", fe_uncorr, u);
    chk("retry_req", retry_req, rq);
    @(negedge core_clk);
    chk("io_err_rep", io_err_rep, u & io);
    chk("mc_int", mc_int, mc);
    if (mc)
      logchk(a);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(negedge core_clk);
    chk("rst_outs", {mem_we, fe_valid, mc_int, log_we}, 0);
    rst_n = 1;
    for (int i = 0; i < 5; i++) begin
      st(i[15:0], dv[i]);
      fe(i[15:0], dv[i], fv[i], 0, 0, 0, 0, 0);
    end
    st(16'h0008, dv[0]);
    fe(16'h0008, dv[0], 72'h3, 0, 1, 1, 1, 0);
    fe(16'h0008, dv[0], 72'h1, 0, 1, 0, 0, 0);
    fe(16'h0008, dv[0], 72'h3, 0, 1, 1, 1, 0);
    fe(16'h0008, dv[0], 72'h3, 0, 1, 1, 0, 1);
    fe(16'h0008, dv[0], 72'h3, 1, 0, 1, 0, 0);
    mc_enable = 0;
    fe(16'h0008, dv[0], 72'h5, 0, 0, 1, 0, 0);
    repeat (4) @(negedge core_clk);
    chk("mc_masked", mc_int, 0);
    mc_enable = 1;
    for (int k = 0; k < 4 && mc_int !== 1; k++)
      @(negedge core_clk);
    chk("mc_late", mc_int, 1);
    logchk(16'h0008);
    // mid-run reset drops a pending machine check
    mc_enable = 0;
    fe(16'h0008, dv[0], 72'h5, 0, 0, 1, 0, 0);
    rst_n = 0;
    @(negedge core_clk);
    chk("rst_mid", {fe_valid, mc_int, log_we, retry_req}, 0);
    rst_n = 1;
    mc_enable = 1;
    repeat (3) @(negedge core_clk);
    chk("mc_cleared", {mc_int, log_we}, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
